/* File: hw/audrt_pkg.sv */
`default_nettype none
package audrt_pkg;
    localparam int SW = 24;
    localparam int NCH = 16;
    localparam int NAES = 16;
    localparam int NPAIR = 8;
    localparam int NANA = 4;
    localparam int NCIN = 52;
    localparam int SELW = 6;
    localparam int NSRC = 64;
    // Path source map for the input crosspoint
    localparam int PS_AES = 16;
    localparam int PS_ANA = 32;
    localparam int PS_FLEX = 36;
    // Card input map for flex nodes and metering
    localparam int CI_EMB2 = 16;
    localparam int CI_AES = 32;
    localparam int CI_ANA = 48;
    // Output source map, path 1 bus then path 2 bus
    localparam int OS_DML = 32;
    localparam int OS_DMR = 33;
    localparam int OS_OFX = 34;
    localparam int NOFX = 2;
    localparam logic [SELW-1:0] OS_ALT_FLIP = 6'h10;
    localparam logic [SELW-1:0] OS_BUS_END = 6'h20;
    localparam int FADE_SHIFT = 4;
    localparam logic [4:0] GAIN_FULL = 5'h10;
    localparam logic [4:0] GAIN_ZERO = 5'h00;
    localparam logic [4:0] GAIN_STEP = 5'h01;
    localparam int PRES_TICKS_DEF = 4800;
    localparam logic [1:0] SDI_SEL_RST = 2'h0;
    localparam logic signed [SW-1:0] SMP_MAX = {1'b0, {(SW-1){1'b1}}};
    localparam logic signed [SW-1:0] SMP_MIN = {1'b1, {(SW-1){1'b0}}};

    typedef logic signed [SW-1:0] audrt_smp_t;
    typedef logic [SELW-1:0] audrt_sel_t;

    typedef struct packed {
        logic [1:0][NCH-1:0][SELW-1:0] in_sel;
        logic [1:0][NCH-1:0][SELW-1:0] emb_sel;
        logic [NAES-1:0][SELW-1:0] aes_sel;
        logic [NANA-1:0][SELW-1:0] ana_sel;
        logic [NCH-1:0][SELW-1:0] fx_a;
        logic [NCH-1:0][SELW-1:0] fx_b;
        logic [4:0][SELW-1:0] dm_sel;
        logic [NOFX-1:0][SELW-1:0] ofx_a;
        logic [NOFX-1:0][SELW-1:0] ofx_b;
    } audrt_cfg_t;

    typedef struct packed {
        logic [1:0][NCH-1:0][SW-1:0] emb;
        logic [NANA-1:0][SW-1:0] ana;
    } audrt_in_t;

    typedef struct packed {
        logic [1:0][NCH-1:0][SW-1:0] emb;
        logic [NAES-1:0][SW-1:0] aes;
        logic [NANA-1:0][SW-1:0] ana;
    } audrt_frame_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_DOWN = 4'b0100,
        ST_UP = 4'b1000
    } audrt_fade_t;

    function automatic audrt_cfg_t audrt_cfg_default();
        audrt_cfg_t c;
        c = '0;
        for (int p = 0; p < 2; p++) begin
            for (int ch = 0; ch < NCH; ch++) begin
                c.in_sel[p][ch] = SELW'(ch);
                c.emb_sel[p][ch] = SELW'(ch);
            end
        end
        return c;
    endfunction

    localparam audrt_cfg_t CFG_RST = audrt_cfg_default();
endpackage
`default_nettype wire

/* File: hw/audrt_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module audrt_buf #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [W-1:0] e1;
    logic [W-1:0] next_e0;
    logic [W-1:0] next_e1;
    logic push;
    logic pop;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_e0 = out_data;
        next_e1 = e1;
        next_cnt = cnt;
        if (pop) begin
            next_e0 = e1;
        end
        if (push) begin
            if (cnt == 2'h0 || (cnt == 2'h1 && pop)) begin
                next_e0 = in_data;
            end else begin
                next_e1 = in_data;
            end
        end
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 2'h0;
            out_data <= '0;
            e1 <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt <= next_cnt;
            out_data <= next_e0;
            e1 <= next_e1;
            // Ready only while a slot is free, so a stalled sink back-pressures the source
            in_ready <= (next_cnt != 2'h2);
            out_valid <= (next_cnt != 2'h0);
        end
    end

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("buffer head changed while stalled");

    property p_full;
        @(posedge sys_clk) disable iff (rst)
        (cnt == 2'h2) |-> !in_ready ##1 (cnt != 2'h0);
    endproperty
    a_full: assert property (p_full) else $error("buffer accepts while full");
endmodule // audrt_buf
`default_nettype wire

/* File: hw/audrt_router.sv */
`timescale 1ns/1ps
`default_nettype none
module audrt_router
    import audrt_pkg::*;
#(
    parameter int PRES_TICKS = PRES_TICKS_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire audrt_in_t in_data,
    input wire logic [NAES-1:0][SW-1:0] aes_smp,
    input wire logic [NPAIR-1:0] aes_pair_valid,
    input wire logic [NPAIR-1:0] aes_nonpcm,
    input wire audrt_cfg_t cfg,
    input wire logic switch_req,
    input wire logic [1:0] switch_sel,
    input wire logic switch_line,
    input wire logic failover_req,
    input wire logic [1:0] failover_sel,
    output logic out_valid,
    input wire logic out_ready,
    output audrt_frame_t out_data,
    output logic [1:0] sdi_sel,
    output logic switch_busy,
    output logic [NPAIR-1:0] aes_is_data,
    output logic [NCIN-1:0] ch_present,
    output logic [NCIN-1:0][SW-2:0] ch_peak
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic audrt_smp_t add_sat(input audrt_smp_t a, input audrt_smp_t b,
                                           input audrt_smp_t c);
        logic signed [SW+1:0] v;
        v = a;
        v = v + b;
        v = v + c;
        if (v > SMP_MAX) begin
            return SMP_MAX;
        end else if (v < SMP_MIN) begin
            return SMP_MIN;
        end
        return v[SW-1:0];
    endfunction

    function automatic logic [SW-2:0] abs_lvl(input audrt_smp_t x);
        audrt_smp_t n;
        n = -x;
        if (x == SMP_MIN) begin
            return {(SW-1){1'b1}};
        end else if (x < 0) begin
            return n[SW-2:0];
        end
        return x[SW-2:0];
    endfunction

    function automatic audrt_smp_t duck(input audrt_smp_t x, input logic [4:0] g);
        logic signed [SW+5:0] m;
        m = x * $signed({1'b0, g});
        return m[SW+FADE_SHIFT-1:FADE_SHIFT];
    endfunction

    logic tick;
    audrt_cfg_t cfg_act;
    audrt_cfg_t next_cfg;
    audrt_frame_t frame;
    logic [$bits(audrt_frame_t)-1:0] buf_out;

    assign tick = in_valid && in_ready;

    // ****************************************
    // Configuration
    // ****************************************
    always_comb begin
        next_cfg = tick ? cfg : cfg_act;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_act <= CFG_RST;
        end else begin
            cfg_act <= next_cfg;
        end
    end

    // ****************************************
    // AES classification and rate conversion
    // ****************************************
    audrt_smp_t hold_new [NAES];
    audrt_smp_t hold_old [NAES];
    audrt_smp_t next_new [NAES];
    audrt_smp_t next_old [NAES];
    audrt_smp_t rate_converter [NAES];
    logic [NPAIR-1:0] next_is_data;

    always_comb begin
        next_new = hold_new;
        next_old = hold_old;
        next_is_data = aes_is_data;
        for (int k = 0; k < NPAIR; k++) begin
            if (aes_pair_valid[k]) begin
                next_is_data[k] = aes_nonpcm[k];
                for (int i = 2 * k; i < 2 * k + 2; i++) begin
                    next_old[i] = hold_new[i];
                    next_new[i] = audrt_smp_t'(aes_smp[i]);
                end
            end
        end
        for (int i = 0; i < NAES; i++) begin
            if (aes_is_data[i / 2]) begin
                rate_converter[i] = hold_new[i];
            end else begin
                rate_converter[i] = SW'((SW+1)'(hold_new[i] + hold_old[i]) >>> 1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_new <= '{default: '0};
            hold_old <= '{default: '0};
            aes_is_data <= '0;
        end else begin
            hold_new <= next_new;
            hold_old <= next_old;
            aes_is_data <= next_is_data;
        end
    end

    // ****************************************
    // Clean switch sequencer
    // ****************************************
    audrt_fade_t st;
    audrt_fade_t next_st;
    logic [4:0] gain;
    logic [4:0] next_gain;
    logic [1:0] tgt;
    logic [1:0] next_tgt;
    logic [1:0] next_sel;

    always_comb begin
        next_st = st;
        next_gain = gain;
        next_tgt = tgt;
        next_sel = sdi_sel;
        if (failover_req) begin
            next_sel = failover_sel;
            next_st = ST_IDLE;
            next_gain = GAIN_FULL;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (switch_req) begin
                        next_tgt = switch_sel;
                        next_st = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (switch_line) begin
                        next_st = ST_DOWN;
                    end
                end
                ST_DOWN: begin
                    if (tick) begin
                        if (gain == GAIN_ZERO) begin
                            next_sel = tgt;
                            next_st = ST_UP;
                        end else begin
                            next_gain = gain - GAIN_STEP;
                        end
                    end
                end
                ST_UP: begin
                    if (tick) begin
                        if (gain == GAIN_FULL) begin
                            next_st = ST_IDLE;
                        end else begin
                            next_gain = gain + GAIN_STEP;
                        end
                    end
                end
                default: begin
                    next_st = ST_IDLE;
                    next_gain = GAIN_FULL;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= ST_IDLE;
            gain <= GAIN_FULL;
            tgt <= SDI_SEL_RST;
            sdi_sel <= SDI_SEL_RST;
            switch_busy <= 1'b0;
        end else begin
            st <= next_st;
            gain <= next_gain;
            tgt <= next_tgt;
            sdi_sel <= next_sel;
            switch_busy <= (next_st != ST_IDLE);
        end
    end

    // ****************************************
    // Mixing and crosspoints
    // ****************************************
    audrt_smp_t cin [NSRC];
    audrt_smp_t fx [NCH];
    audrt_smp_t psrc [2][NSRC];
    audrt_smp_t bus [2][NCH];
    audrt_smp_t bflat [NSRC];
    audrt_smp_t obus [NSRC];
    audrt_smp_t downmix_left_out;
    audrt_smp_t downmix_right_out;
    audrt_smp_t left_surround_in;
    audrt_smp_t right_surround_in;
    audrt_sel_t esel;

    always_comb begin
        cin = '{default: '0};
        psrc = '{default: '{default: '0}};
        bflat = '{default: '0};
        frame = '0;
        esel = '0;
        for (int i = 0; i < NCH; i++) begin
            cin[i] = audrt_smp_t'(in_data.emb[0][i]);
            cin[CI_EMB2 + i] = audrt_smp_t'(in_data.emb[1][i]);
            cin[CI_AES + i] = rate_converter[i];
        end
        for (int i = 0; i < NANA; i++) begin
            cin[CI_ANA + i] = audrt_smp_t'(in_data.ana[i]);
        end
        for (int k = 0; k < NCH; k++) begin
            fx[k] = add_sat(cin[cfg_act.fx_a[k]], cin[cfg_act.fx_b[k]], '0);
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < NCH; i++) begin
                psrc[p][i] = duck(cin[p * CI_EMB2 + i], gain);
                psrc[p][PS_AES + i] = cin[CI_AES + i];
                psrc[p][PS_FLEX + i] = fx[i];
            end
            for (int i = 0; i < NANA; i++) begin
                psrc[p][PS_ANA + i] = cin[CI_ANA + i];
            end
            for (int c = 0; c < NCH; c++) begin
                bus[p][c] = psrc[p][cfg_act.in_sel[p][c]];
                bflat[p * NCH + c] = bus[p][c];
            end
        end
        left_surround_in = bflat[cfg_act.dm_sel[3]];
        right_surround_in = bflat[cfg_act.dm_sel[4]];
        downmix_left_out = add_sat(bflat[cfg_act.dm_sel[0]], bflat[cfg_act.dm_sel[2]] >>> 1,
                                   left_surround_in >>> 1);
        downmix_right_out = add_sat(bflat[cfg_act.dm_sel[1]], bflat[cfg_act.dm_sel[2]] >>> 1,
                                    right_surround_in >>> 1);
        obus = bflat;
        obus[OS_DML] = downmix_left_out;
        obus[OS_DMR] = downmix_right_out;
        for (int k = 0; k < NOFX; k++) begin
            obus[OS_OFX + k] = add_sat(bflat[cfg_act.ofx_a[k]], bflat[cfg_act.ofx_b[k]], '0);
        end
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < NCH; c++) begin
                esel = cfg_act.emb_sel[p][c];
                if (p == 1 && esel < OS_BUS_END) begin
                    esel = esel ^ OS_ALT_FLIP;
                end
                frame.emb[p][c] = obus[esel];
            end
        end
        for (int i = 0; i < NAES; i++) begin
            frame.aes[i] = obus[cfg_act.aes_sel[i]];
        end
        for (int i = 0; i < NANA; i++) begin
            frame.ana[i] = obus[cfg_act.ana_sel[i]];
        end
    end

    // Two-slot buffer keeps a frame when the embedder stalls
    audrt_buf #(
        .W($bits(audrt_frame_t))
    ) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(frame),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );
    assign out_data = audrt_frame_t'(buf_out);

    // ****************************************
    // Input metering
    // ****************************************
    logic [15:0] win_cnt;
    logic [15:0] next_win;
    logic [NCIN-1:0] seen;
    logic [NCIN-1:0] next_seen;
    logic [NCIN-1:0] next_present;
    logic [NCIN-1:0][SW-2:0] run;
    logic [NCIN-1:0][SW-2:0] next_run;
    logic [NCIN-1:0][SW-2:0] next_peak;
    logic [SW-2:0] lvl;
    logic win_end;

    always_comb begin
        win_end = tick && (win_cnt == 16'(PRES_TICKS - 1));
        next_win = tick ? (win_end ? 16'h0000 : win_cnt + 16'h0001) : win_cnt;
        next_seen = seen;
        next_run = run;
        next_present = ch_present;
        next_peak = ch_peak;
        lvl = '0;
        for (int i = 0; i < NCIN; i++) begin
            if (tick) begin
                lvl = abs_lvl(cin[i]);
                next_seen[i] = seen[i] | (cin[i] != '0);
                next_run[i] = (lvl > run[i]) ? lvl : run[i];
                if (win_end) begin
                    next_present[i] = next_seen[i];
                    next_peak[i] = next_run[i];
                    next_seen[i] = 1'b0;
                    next_run[i] = '0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            win_cnt <= 16'h0000;
            seen <= '0;
            run <= '0;
            ch_present <= '0;
            ch_peak <= '0;
        end else begin
            win_cnt <= next_win;
            seen <= next_seen;
            run <= next_run;
            ch_present <= next_present;
            ch_peak <= next_peak;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_cfg_hold;
        @(posedge sys_clk) disable iff (rst)
        !tick |=> cfg_act == $past(cfg_act);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("routing changed between samples");

    property p_class;
        @(posedge sys_clk) disable iff (rst)
        aes_pair_valid[3] |=> aes_is_data[3] == $past(aes_nonpcm[3]);
    endproperty
    a_class: assert property (p_class) else $error("pair class not updated");

    property p_bypass;
        @(posedge sys_clk) disable iff (rst)
        aes_is_data[3] |-> rate_converter[6] == hold_new[6] && rate_converter[7] == hold_new[7];
    endproperty
    a_bypass: assert property (p_bypass) else $error("converter not bypassed for data");

    property p_wait_line;
        @(posedge sys_clk) disable iff (rst)
        st == ST_WAIT && !switch_line && !failover_req |=> st == ST_WAIT && gain == GAIN_FULL;
    endproperty
    a_wait_line: assert property (p_wait_line) else $error("fade began before switch line");

    property p_commit;
        @(posedge sys_clk) disable iff (rst)
        st == ST_DOWN && tick && gain == GAIN_ZERO && !failover_req |=> sdi_sel == $past(tgt) && st == ST_UP;
    endproperty
    a_commit: assert property (p_commit) else $error("input not changed at silence");

    property p_failover;
        @(posedge sys_clk) disable iff (rst)
        failover_req |=> sdi_sel == $past(failover_sel) && gain == GAIN_FULL && !switch_busy;
    endproperty
    a_failover: assert property (p_failover) else $error("failover not immediate");

    property p_sat;
        @(posedge sys_clk) disable iff (rst)
        cin[cfg_act.fx_a[0]] > 0 && cin[cfg_act.fx_b[0]] > 0 |-> fx[0] > 0;
    endproperty
    a_sat: assert property (p_sat) else $error("flex sum wrapped");

    property p_present;
        @(posedge sys_clk) disable iff (rst)
        win_end && cin[0] != '0 |=> ch_present[0] ##1 ch_peak[0] != '0 || ch_present[0];
    endproperty
    a_present: assert property (p_present) else $error("presence not reported");
endmodule // audrt_router
`default_nettype wire

/* File: dv/audrt_far.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Far-side sink
// ****************
module audrt_far
    import audrt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire audrt_frame_t out_data,
    output audrt_frame_t last,
    output logic [15:0] n
);
    // Ready lags stall by one edge, like a busy embedder
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_ready <= 1'b0;
            n <= 16'h0000;
            last <= '0;
        end else begin
            out_ready <= !stall;
            if (out_valid && out_ready) begin
                last <= out_data;
                n <= n + 16'h0001;
            end
        end
    end
endmodule // audrt_far
`default_nettype wire

/* File: dv/audrt_router_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Router bench
// ****************
module audrt_router_bench;
    import audrt_pkg::*;
    logic sys_clk = 0, rst = 1, in_valid = 0, in_ready, out_valid, out_ready, stall = 0;
    logic switch_req = 0, switch_line = 0, failover_req = 0, switch_busy;
    logic [1:0] switch_sel = 0, failover_sel = 0, sdi_sel;
    logic [NAES-1:0][SW-1:0] aes_smp = '0;
    logic [NPAIR-1:0] aes_pair_valid = '0, aes_nonpcm = '0, aes_is_data;
    logic [NCIN-1:0] ch_present;
    logic [NCIN-1:0][SW-2:0] ch_peak;
    logic [15:0] n;
    audrt_in_t in_data = '0;
    audrt_cfg_t cfg = CFG_RST;
    audrt_frame_t out_data, last, fr;
    int errors = 0, samples_checked = 0, cyc = 0;

    audrt_router #(.PRES_TICKS(4)) i_audrt_router (.sys_clk, .rst, .in_valid, .in_ready, .in_data,
        .aes_smp, .aes_pair_valid, .aes_nonpcm, .cfg, .switch_req, .switch_sel, .switch_line,
        .failover_req, .failover_sel, .out_valid, .out_ready, .out_data, .sdi_sel, .switch_busy,
        .aes_is_data, .ch_present, .ch_peak);
    audrt_far i_audrt_far (.sys_clk, .rst, .stall, .out_valid, .out_ready, .out_data, .last, .n);

    initial forever #2.5 sys_clk = ~sys_clk;
    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_smp(string nm, audrt_smp_t e, audrt_smp_t s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmp_flag(string nm, logic [7:0] e, logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic audrt_in_t mk(int b);
        audrt_in_t f;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < NCH; c++) f.emb[p][c] = SW'(b * 256 + p * 16 + c);
        for (int a = 0; a < NANA; a++) f.ana[a] = SW'(b * 256 + 64 + a);
        return f;
    endfunction
    // Valid stays up between back-to-back sends; wait_got drops it
    task automatic send(audrt_in_t f);
        in_data <= f;
        in_valid <= 1'b1;
        do @(posedge sys_clk); while (in_ready !== 1'b1);
    endtask
    task automatic wait_got();
        logic [15:0] n0;
        n0 = n;
        in_valid <= 1'b0;
        for (int i = 0; i < 20 && n === n0; i++) @(posedge sys_clk);
        cmp_flag("frame out", 8'h01, {7'h00, n !== n0});
        fr = last;
    endtask
    task automatic xfer(audrt_in_t f);
        send(f);
        wait_got();
    endtask
    task automatic aes(int k, logic d, audrt_smp_t v);
        aes_smp[2*k] <= v;
        aes_smp[2*k+1] <= v;
        aes_nonpcm[k] <= d;
        aes_pair_valid[k] <= 1'b1;
        @(posedge sys_clk);
        aes_pair_valid <= '0;
        @(posedge sys_clk);
    endtask

    task automatic t_default();
        // Pending routing must not touch the first frame after reset
        cfg <= '0;
        xfer(mk(1));
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < NCH; c++) cmp_smp("emb", mk(1).emb[p][c], fr.emb[p][c]);
        cfg <= CFG_RST;
        xfer(mk(1));
    endtask
    task automatic t_route();
        audrt_cfg_t c;
        c = CFG_RST;
        c.in_sel[1][5] = SELW'(PS_ANA + 2);
        c.ana_sel[0] = 6'h15;
        c.emb_sel[0][7] = OS_ALT_FLIP + 6'h07;
        cfg <= c;
        xfer(mk(2));
        cmp_smp("old cfg", mk(2).emb[1][5], fr.emb[1][5]);
        xfer(mk(3));
        cmp_smp("in xp", mk(3).ana[2], fr.emb[1][5]);
        cmp_smp("ana out", mk(3).ana[2], fr.ana[0]);
        cmp_smp("alt bus", mk(3).emb[1][7], fr.emb[0][7]);
        cmp_smp("aes out", mk(3).emb[0][0], fr.aes[0]);
    endtask
    task automatic t_aes();
        audrt_cfg_t c;
        c = CFG_RST;
        c.in_sel[0][0] = SELW'(PS_AES + 6);
        cfg <= c;
        xfer(mk(0));
        aes(3, 1'b1, 24'h123456);
        cmp_flag("class", 8'h01, {7'h00, aes_is_data[3]});
        xfer(mk(0));
        cmp_smp("bypass", 24'h123456, fr.aes[0]);
        // Two different samples so the average differs from either
        aes(3, 1'b0, 24'hF00000);
        aes(3, 1'b0, 24'h300000);
        cmp_flag("class", 8'h00, {7'h00, aes_is_data[3]});
        xfer(mk(0));
        cmp_smp("convert", 24'h100000, fr.aes[0]);
    endtask
    task automatic t_mix();
        audrt_cfg_t c;
        audrt_in_t f;
        c = CFG_RST;
        c.aes_sel[1] = SELW'(OS_DML);
        c.ana_sel[3] = SELW'(OS_DMR);
        c.emb_sel[1][2] = SELW'(OS_DML);
        c.fx_b[0] = SELW'(CI_ANA);
        c.in_sel[0][1] = SELW'(PS_FLEX);
        c.ofx_a[0] = 6'h05;
        c.ofx_b[0] = 6'h15;
        c.ana_sel[1] = SELW'(OS_OFX);
        cfg <= c;
        f = mk(0);
        f.emb[0][0] = SMP_MAX;
        f.emb[1][5] = 24'h000020;
        xfer(f);
        xfer(f);
        cmp_smp("mix left", SMP_MAX, fr.aes[1]);
        cmp_smp("mix right", SMP_MAX, fr.ana[3]);
        cmp_smp("mix emb", SMP_MAX, fr.emb[1][2]);
        cmp_smp("flex in", SMP_MAX, fr.emb[0][1]);
        cmp_smp("flex out", 24'h000025, fr.ana[1]);
        f.emb[0][0] = SMP_MIN;
        xfer(f);
        cmp_smp("mix low", SMP_MIN, fr.aes[1]);
        cfg <= CFG_RST;
        xfer(f);
    endtask
    task automatic t_buf();
        stall <= 1'b1;
        send(mk(5));
        send(mk(6));
        in_valid <= 1'b0;
        @(posedge sys_clk);
        cmp_flag("full", 8'h00, {7'h00, in_ready});
        stall <= 1'b0;
        wait_got();
        cmp_smp("order", mk(5).emb[1][3], fr.emb[1][3]);
        wait_got();
        cmp_smp("order", mk(6).emb[1][3], fr.emb[1][3]);
    endtask
    task automatic t_meter();
        audrt_in_t f;
        f = mk(0);
        f.emb[0][2] = 24'hFFFFFB;
        // Silent neighbour must read as absent
        f.emb[0][3] = '0;
        repeat (8) xfer(f);
        cmp_flag("present", 8'h02, {6'h00, ch_present[2], ch_present[3]});
        cmp_smp("peak", 24'h000005, {1'b0, ch_peak[2]});
    endtask
    task automatic t_switch();
        int k;
        logic quiet;
        k = 0;
        quiet = 1'b0;
        failover_sel <= 2'h2;
        failover_req <= 1'b1;
        @(posedge sys_clk);
        failover_req <= 1'b0;
        @(posedge sys_clk);
        cmp_flag("failover", 8'h02, {6'h00, sdi_sel});
        switch_sel <= 2'h1;
        switch_req <= 1'b1;
        @(posedge sys_clk);
        switch_req <= 1'b0;
        @(posedge sys_clk);
        cmp_flag("busy", 8'h01, {7'h00, switch_busy});
        repeat (3) xfer(mk(16));
        cmp_flag("deferred", 8'h02, {6'h00, sdi_sel});
        cmp_smp("no duck", 24'h001000, fr.emb[0][0]);
        switch_line <= 1'b1;
        @(posedge sys_clk);
        switch_line <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            xfer(mk(16));
            if (fr.emb[0][0] === 24'h000000) quiet = 1'b1;
            if (sdi_sel === 2'h1 && k == 0) k = i + 1;
        end
        cmp_flag("fade steps", 8'h11, 8'(k));
        cmp_flag("silence", 8'h01, {7'h00, quiet});
        cmp_flag("done", 8'h00, {7'h00, switch_busy});
        cmp_smp("restored", 24'h001000, fr.emb[0][0]);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_default();
        t_route();
        t_aes();
        t_mix();
        t_buf();
        t_meter();
        t_switch();
        test_done();
    end
endmodule // audrt_router_bench
`default_nettype wire
